/* File: include/mcr_cfg_if.sv */
/*
  Configuration carrier from the register bank to the conversion sequencer.
  Assumes one clock domain shared by both ends.
*/
`default_nettype none
interface mcr_cfg_if;
  logic       single_channel_convert;
  logic       averaging_off;
  logic [2:0] selected_channel;
  logic [2:0] active_channel;
  logic       conversion_done;
  modport bank (output single_channel_convert, output averaging_off, output selected_channel,
                input active_channel, input conversion_done);
  modport seq  (input single_channel_convert, input averaging_off, input selected_channel,
                output active_channel, output conversion_done);
endinterface : mcr_cfg_if
`default_nettype wire

/* File: include/mcr_params.svh */
/*
  Register offsets, field positions, reset values and timing counts of the monitor configuration registers.
  Assumes inclusion by bare name from files that need these constants.
*/
`ifndef MCR_PARAMS_SVH
`define MCR_PARAMS_SVH

`define MCR_OFF_TEST_EN        8'h6F
`define MCR_OFF_R1_OFFSET      8'h70
`define MCR_OFF_LOC_OFFSET     8'h71
`define MCR_OFF_R2_OFFSET      8'h72
`define MCR_OFF_CFG_TWO        8'h73
`define MCR_OFF_LOCK_CTRL      8'h78
`define MCR_OFF_CFG_FIVE       8'h7C
`define MCR_OFF_CFG_FOUR       8'h7D
`define MCR_OFF_CHAN_SEL       8'h55
`define MCR_OFF_SEQ_STATUS     8'h79

`define MCR_RST_BYTE           8'h00
`define MCR_TEST_BIT           0
`define MCR_PRES_BIT           0
`define MCR_AVG_BIT            4
`define MCR_ATTENUATOR_BYPASS_BIT           5
`define MCR_SINGLE_CHANNEL_CONVERT_BIT           6
`define MCR_RES_BIT            7
`define MCR_LOCK_BIT           1
`define MCR_RANGE_BIT          1
`define MCR_CFG_TWO_WMASK      8'h71
`define MCR_NUM_CH             3'h7

`define MCR_DWELL_AVG          8'hFF
`define MCR_DWELL_FAST         8'h0F

`endif

/* File: include/mcr_pkg.sv */
/*
  Types shared by the monitor configuration register files.
  Assumes mcr_params.svh is on the include path.
*/
`default_nettype none
package mcr_pkg;
  typedef enum logic [2:0] {
    MCR_IDLE  = 3'b001,
    MCR_ACK   = 3'b010,
    MCR_HOLD  = 3'b100
  } mcr_bus_state_t;

  typedef struct packed {
    mcr_bus_state_t bus_state;
    logic           map_hit;
    logic [7:0]     rdata;
    logic [7:0]     test_en;
    logic [7:0]     r1_offset;
    logic [7:0]     loc_offset;
    logic [7:0]     r2_offset;
    logic [7:0]     cfg_two;
    logic [7:0]     cfg_four;
    logic [7:0]     cfg_five;
    logic [7:0]     lock_ctrl;
    logic [7:0]     chan_sel;
  } mcr_state_t;

  typedef struct packed {
    logic [2:0] channel;
    logic [7:0] dwell;
  } mcr_seq_state_t;
endpackage : mcr_pkg
`default_nettype wire

/* File: rtl/mcr_bank.sv */
/*
  Configuration and test register bank of a thermal and voltage monitor, as a classic Wishbone slave.
  Assumes an 8-bit register map on byte addresses, synchronous inputs and one 100 MHz clock.
*/
// Design decision made here: the Wishbone interface to the registers.
// Contract
// - Test enable bit 0 enters logic tree test mode; clearing it leaves.
// - Lock bit set makes test enable, offsets and config two read-only.
// - Each offset register is added to its channel's temperature result.
// - Config five bit 1 selects offset range and resolution.
// - Presence enable bit 0 lets bits three to one report four-wire fans.
// - Bits one to three are read-only, one when a four-wire fan found.
// - Config two bit 4 disables averaging, conversion sixteen times faster.
// - Config two bit 5 bypasses attenuators on four voltage inputs together.
// - Config four bits seven to four bypass attenuators per channel.
// - Config two bit 6 selects single-channel continuous conversion.
// - Single channel chosen by bits seven to five of the selector register.
`include "mcr_params.svh"
`default_nettype none
module mcr_bank
  import mcr_pkg::*;
(
  // Clock and reset.
  input  wire logic       CORE_CLK,
  input  wire logic       RST,
  // Wishbone slave.
  input  wire logic       CYC_I,
  input  wire logic       STB_I,
  input  wire logic       WE_I,
  input  wire logic [7:0] ADR_I,
  input  wire logic [3:0] SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic [31:0]     DAT_O,
  output logic            ACK_O,
  output logic            ERR_O,
  // Fan presence detectors per speed input.
  input  wire logic [2:0] FOUR_WIRE_FOUND,
  // Raw temperature results: remote one, local, remote two.
  input  wire logic [7:0] RAW_TEMP_R1,
  input  wire logic [7:0] RAW_TEMP_LOC,
  input  wire logic [7:0] RAW_TEMP_R2,
  // Corrected temperature results.
  output logic [7:0]      ADJ_TEMP_R1,
  output logic [7:0]      ADJ_TEMP_LOC,
  output logic [7:0]      ADJ_TEMP_R2,
  // Analog front-end controls.
  output logic            LOGIC_TREE_TEST_MODE,
  output logic [3:0]      ATTENUATOR_BYPASS,
  output logic            AVERAGING_OFF,
  output logic            SINGLE_CHANNEL_CONVERT,
  output logic [2:0]      ACTIVE_CHANNEL,
  output logic            CONVERSION_DONE
);
  mcr_state_t  st_reg;
  mcr_state_t  st_next;
  localparam mcr_state_t ST_RESET = '{bus_state: MCR_IDLE, default: '0};
  mcr_cfg_if   cfg ();
  logic        req;
  logic        wr;
  logic        locked;
  logic        mapped;
  logic [7:0]  wbyte;
  logic [7:0]  cfg_two_view;
  logic [7:0]  raw_t    [3];
  logic [7:0]  offs     [3];
  logic [7:0]  adj_t    [3];

  assign req    = CYC_I && STB_I && (st_reg.bus_state == MCR_IDLE);
  // A write lands at the edge where the master samples the answer, while its request still stands.
  assign wr     = CYC_I && STB_I && WE_I && SEL_I[0] && (st_reg.bus_state == MCR_ACK);
  assign wbyte  = DAT_I[7:0];
  assign locked = st_reg.lock_ctrl[`MCR_LOCK_BIT];

  always_comb begin
    case (ADR_I)
      `MCR_OFF_TEST_EN, `MCR_OFF_R1_OFFSET, `MCR_OFF_LOC_OFFSET, `MCR_OFF_R2_OFFSET,
      `MCR_OFF_CFG_TWO, `MCR_OFF_LOCK_CTRL, `MCR_OFF_CFG_FIVE, `MCR_OFF_CFG_FOUR,
      `MCR_OFF_CHAN_SEL, `MCR_OFF_SEQ_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Detector bits only report while presence detection is enabled.
  assign cfg_two_view = {st_reg.cfg_two[7:4],
                         st_reg.cfg_two[`MCR_PRES_BIT] ? FOUR_WIRE_FOUND : 3'h0,
                         st_reg.cfg_two[`MCR_PRES_BIT]};

  always_comb begin
    st_next = st_reg;
    case (st_reg.bus_state)
      MCR_IDLE: begin
        if (req) begin
          st_next.bus_state = MCR_ACK;
          st_next.map_hit   = mapped;
          st_next.rdata     = 8'h00;
          if (!WE_I) begin
            case (ADR_I)
              `MCR_OFF_TEST_EN:    st_next.rdata = st_reg.test_en;
              `MCR_OFF_R1_OFFSET:  st_next.rdata = st_reg.r1_offset;
              `MCR_OFF_LOC_OFFSET: st_next.rdata = st_reg.loc_offset;
              `MCR_OFF_R2_OFFSET:  st_next.rdata = st_reg.r2_offset;
              `MCR_OFF_CFG_TWO:    st_next.rdata = cfg_two_view;
              `MCR_OFF_LOCK_CTRL:  st_next.rdata = st_reg.lock_ctrl;
              `MCR_OFF_CFG_FIVE:   st_next.rdata = st_reg.cfg_five;
              `MCR_OFF_CFG_FOUR:   st_next.rdata = st_reg.cfg_four;
              `MCR_OFF_CHAN_SEL:   st_next.rdata = st_reg.chan_sel;
              `MCR_OFF_SEQ_STATUS: st_next.rdata = {4'h0, cfg.conversion_done, cfg.active_channel};
              default:             st_next.rdata = 8'h00;
            endcase
          end
        end
      end
      MCR_ACK: begin
        st_next.bus_state = MCR_HOLD;
        if (wr) begin
            case (ADR_I)
              // A locked register keeps its value; the access is still acknowledged.
              `MCR_OFF_TEST_EN: begin
                if (!locked) begin
                  st_next.test_en = wbyte;
                end
              end
              `MCR_OFF_R1_OFFSET: begin
                if (!locked) begin
                  st_next.r1_offset = wbyte;
                end
              end
              `MCR_OFF_LOC_OFFSET: begin
                if (!locked) begin
                  st_next.loc_offset = wbyte;
                end
              end
              `MCR_OFF_R2_OFFSET: begin
                if (!locked) begin
                  st_next.r2_offset = wbyte;
                end
              end
              `MCR_OFF_CFG_TWO: begin
                // Detector bits are read-only and never stored.
                if (!locked) begin
                  st_next.cfg_two = wbyte & `MCR_CFG_TWO_WMASK;
                  st_next.cfg_two[`MCR_RES_BIT] = wbyte[`MCR_RES_BIT];
                end
              end
              `MCR_OFF_LOCK_CTRL: begin
                // Once set, lock holds until reset.
                st_next.lock_ctrl = wbyte | (st_reg.lock_ctrl & 8'h02);
              end
              `MCR_OFF_CFG_FIVE:   st_next.cfg_five = wbyte;
              `MCR_OFF_CFG_FOUR:   st_next.cfg_four = wbyte;
              `MCR_OFF_CHAN_SEL:   st_next.chan_sel = wbyte;
              default: begin
              end
            endcase
        end
      end
      MCR_HOLD: begin
        // Wait for the master to release so one request never answers twice.
        if (!(CYC_I && STB_I)) begin
          st_next.bus_state = MCR_IDLE;
        end
      end
      default: begin
        st_next.bus_state = MCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // The address decode is kept from the taking edge, so the answer never depends on a moving address.
  assign ACK_O = (st_reg.bus_state == MCR_ACK) && st_reg.map_hit;
  assign ERR_O = (st_reg.bus_state == MCR_ACK) && !st_reg.map_hit;
  assign DAT_O = {24'h000000, st_reg.rdata};

  assign raw_t[0] = RAW_TEMP_R1;
  assign raw_t[1] = RAW_TEMP_LOC;
  assign raw_t[2] = RAW_TEMP_R2;
  assign offs[0]  = st_reg.r1_offset;
  assign offs[1]  = st_reg.loc_offset;
  assign offs[2]  = st_reg.r2_offset;

  // Offset is signed; range bit chooses 1 degree steps or half degree steps.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_offset
      logic [7:0] scaled;
      assign scaled = st_reg.cfg_five[`MCR_RANGE_BIT] ? {offs[gi][7], offs[gi][7:1]} : offs[gi];
      assign adj_t[gi] = raw_t[gi] + scaled;
    end
  endgenerate

  assign ADJ_TEMP_R1  = adj_t[0];
  assign ADJ_TEMP_LOC = adj_t[1];
  assign ADJ_TEMP_R2  = adj_t[2];

  assign LOGIC_TREE_TEST_MODE = st_reg.test_en[`MCR_TEST_BIT];
  // Global bypass ORs with per-channel bits.
  assign ATTENUATOR_BYPASS = {4{st_reg.cfg_two[`MCR_ATTENUATOR_BYPASS_BIT]}} | st_reg.cfg_four[7:4];
  assign AVERAGING_OFF          = st_reg.cfg_two[`MCR_AVG_BIT];
  assign SINGLE_CHANNEL_CONVERT = st_reg.cfg_two[`MCR_SINGLE_CHANNEL_CONVERT_BIT];

  assign cfg.single_channel_convert = st_reg.cfg_two[`MCR_SINGLE_CHANNEL_CONVERT_BIT];
  assign cfg.averaging_off          = st_reg.cfg_two[`MCR_AVG_BIT];
  assign cfg.selected_channel       = st_reg.chan_sel[7:5];

  mcr_sequencer u_seq (
    .clk (CORE_CLK),
    .rst (RST),
    .cfg (cfg)
  );

  assign ACTIVE_CHANNEL  = cfg.active_channel;
  assign CONVERSION_DONE = cfg.conversion_done;
endmodule : mcr_bank
`default_nettype wire

/* File: rtl/mcr_sequencer.sv */
/*
  Conversion sequencer: round robin over inputs or dwell on one selected input.
  Assumes the register bank drives its configuration through mcr_cfg_if.
*/
`include "mcr_params.svh"
`default_nettype none
module mcr_sequencer
  import mcr_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Configuration.
  mcr_cfg_if.seq    cfg
);
  mcr_seq_state_t s_reg;
  mcr_seq_state_t s_next;
  logic [7:0]     dwell_len;

  // Without averaging each slot is sixteen times shorter.
  assign dwell_len = cfg.averaging_off ? `MCR_DWELL_FAST : `MCR_DWELL_AVG;

  always_comb begin
    s_next = s_reg;
    if (s_reg.dwell >= dwell_len) begin
      s_next.dwell = 8'h00;
      if (cfg.single_channel_convert) begin
        s_next.channel = cfg.selected_channel;
      end else if (s_reg.channel == `MCR_NUM_CH) begin
        s_next.channel = 3'h0;
      end else begin
        s_next.channel = s_reg.channel + 3'h1;
      end
    end else begin
      s_next.dwell = s_reg.dwell + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign cfg.active_channel  = s_reg.channel;
  assign cfg.conversion_done = (s_reg.dwell >= dwell_len);
endmodule : mcr_sequencer
`default_nettype wire

/* File: sim/mcr_bank_props.sv */
/*
  Concurrent checks on the ports of the monitor configuration register bank.
  Assumes one clock domain and a synchronous active-high reset.
*/
`default_nettype none
module mcr_bank_props (
  // Clock and reset.
  input wire logic        CORE_CLK,
  input wire logic        RST,
  // Wishbone slave.
  input wire logic        CYC_I,
  input wire logic        STB_I,
  input wire logic        WE_I,
  input wire logic [7:0]  ADR_I,
  input wire logic [31:0] DAT_O,
  input wire logic        ACK_O,
  input wire logic        ERR_O,
  // Results and controls.
  input wire logic [7:0]  RAW_TEMP_R1,
  input wire logic [7:0]  ADJ_TEMP_R1,
  input wire logic        LOGIC_TREE_TEST_MODE,
  input wire logic        AVERAGING_OFF,
  input wire logic        SINGLE_CHANNEL_CONVERT,
  input wire logic [2:0]  ACTIVE_CHANNEL,
  input wire logic        CONVERSION_DONE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  a_ack_pulse: assert property (ACK_O || ERR_O |=> !ACK_O && !ERR_O) else $error("bus answer held too long");
  a_answer_cause: assert property (!$past(RST) && (ACK_O || ERR_O) |-> $past(CYC_I && STB_I) && !(ACK_O && ERR_O))
    else $error("bus answer without a request");
  a_read_upper: assert property (ACK_O |-> DAT_O[31:8] == 24'h000000) else $error("read data upper bits not zero");
  a_test_cause: assert property (!$past(RST) && $changed(LOGIC_TREE_TEST_MODE) |->
    $past(CYC_I && STB_I && WE_I && ADR_I == 8'h6F)) else $error("test mode moved without a write");
  a_mode_cause: assert property (!$past(RST) && $changed({AVERAGING_OFF, SINGLE_CHANNEL_CONVERT}) |->
    $past(CYC_I && STB_I && WE_I && ADR_I == 8'h73)) else $error("mode bits moved without a write");
  a_offset_cause: assert property (!$past(RST) && $stable(RAW_TEMP_R1) && $changed(ADJ_TEMP_R1) |->
    $past(CYC_I && STB_I && WE_I)) else $error("corrected result moved on its own");
  a_rr_step: assert property (!$past(RST) && $changed(ACTIVE_CHANNEL) && !SINGLE_CHANNEL_CONVERT
    && !$past(SINGLE_CHANNEL_CONVERT) |-> $past(CONVERSION_DONE) && ACTIVE_CHANNEL == $past(ACTIVE_CHANNEL) + 3'h1)
    else $error("channel did not step in order");
  // Disabled while averaging is on, since a slot started in the other mode may run long.
  a_fast_slot: assert property (disable iff (RST || !AVERAGING_OFF) CONVERSION_DONE |=>
    !CONVERSION_DONE [*8] ##1 !CONVERSION_DONE [*7] ##1 CONVERSION_DONE) else $error("fast slot not sixteen cycles");
endmodule // mcr_bank_props
bind mcr_bank mcr_bank_props i_props (.CORE_CLK, .RST, .CYC_I, .STB_I, .WE_I, .ADR_I, .DAT_O, .ACK_O, .ERR_O,
  .RAW_TEMP_R1, .ADJ_TEMP_R1, .LOGIC_TREE_TEST_MODE, .AVERAGING_OFF, .SINGLE_CHANNEL_CONVERT, .ACTIVE_CHANNEL,
  .CONVERSION_DONE);
`default_nettype wire

/* File: sim/mcr_bank_tb_top.sv */
/*
  Self-checking bench for the monitor configuration register bank.
  Assumes the bank answers each Wishbone request one cycle after taking it.
*/
`default_nettype none
module mcr_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CORE_CLK, RST, CYC_I, STB_I, WE_I, ACK_O, ERR_O, LOGIC_TREE_TEST_MODE;
  logic        AVERAGING_OFF, SINGLE_CHANNEL_CONVERT, CONVERSION_DONE;
  logic [7:0]  ADR_I, RAW_TEMP_R1, RAW_TEMP_LOC, RAW_TEMP_R2, ADJ_TEMP_R1, ADJ_TEMP_LOC, ADJ_TEMP_R2, q;
  logic [3:0]  SEL_I, ATTENUATOR_BYPASS;
  logic [31:0] DAT_I, DAT_O;
  logic [2:0]  FOUR_WIRE_FOUND, ACTIVE_CHANNEL, ch;
  logic        e;
  int          fails, n_tests, per, cycles;
  // Rows keep the reserved test enable bits at zero.
  logic [23:0] rows [7] = '{24'h6F0101, 24'h700505, 24'h71FCFC, 24'h727F7F, 24'h7C0202, 24'h7DA0A0, 24'h55A0A0};
  logic [7:0]  locked [5] = '{8'h00, 8'h05, 8'hFC, 8'h7F, 8'h00};
  mcr_bank i_dut (.CORE_CLK, .RST, .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I, .DAT_I, .DAT_O, .ACK_O, .ERR_O,
    .FOUR_WIRE_FOUND, .RAW_TEMP_R1, .RAW_TEMP_LOC, .RAW_TEMP_R2, .ADJ_TEMP_R1, .ADJ_TEMP_LOC, .ADJ_TEMP_R2,
    .LOGIC_TREE_TEST_MODE, .ATTENUATOR_BYPASS, .AVERAGING_OFF, .SINGLE_CHANNEL_CONVERT, .ACTIVE_CHANNEL,
    .CONVERSION_DONE);
  initial begin
    CORE_CLK = 1'h0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // One classic cycle; ends on a falling edge so that outputs behind a write have settled.
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge CORE_CLK);
    CYC_I <= 1'h1;
    STB_I <= 1'h1;
    WE_I <= w;
    ADR_I <= a;
    DAT_I <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (ACK_O !== 1'h1 && ERR_O !== 1'h1 && n < 20);
    q = DAT_O[7:0];
    e = ERR_O;
    if (n >= 20) fails++;
    CYC_I <= 1'h0;
    STB_I <= 1'h0;
    @(negedge CORE_CLK);
  endtask
  task automatic wait_done();
    per = 0;
    do begin
      @(posedge CORE_CLK);
      per++;
    end while (CONVERSION_DONE !== 1'h1 && per < 600);
  endtask
  initial begin
    RST = 1'h1;
    CYC_I = 1'h0;
    STB_I = 1'h0;
    WE_I = 1'h0;
    ADR_I = 8'h00;
    DAT_I = 32'h00000000;
    SEL_I = 4'hF;
    FOUR_WIRE_FOUND = 3'h5;
    {RAW_TEMP_R1, RAW_TEMP_LOC, RAW_TEMP_R2} = 24'h202020;
    repeat (2) @(posedge CORE_CLK);
    RST <= 1'h0;
    for (int i = 0; i < 5; i++) begin
      wb(1'h0, 8'h6F + 8'(i), 8'h00);
      check("reset value", q, 8'h00);
    end
    check("adjusted at reset", ADJ_TEMP_R1, 8'h20);
    $display("Test reset done");
    for (int i = 0; i < 7; i++) begin
      wb(1'h1, rows[i][23:16], rows[i][15:8]);
      wb(1'h0, rows[i][23:16], 8'h00);
      check("register readback", q, rows[i][7:0]);
    end
    check("test mode", LOGIC_TREE_TEST_MODE, 1'h1);
    check("bypass per channel", ATTENUATOR_BYPASS, 4'hA);
    check("halved offsets", {ADJ_TEMP_R1, ADJ_TEMP_LOC, ADJ_TEMP_R2}, 24'h221E5F);
    wb(1'h1, 8'h7C, 8'h00);
    check("full offsets", {ADJ_TEMP_R1, ADJ_TEMP_LOC, ADJ_TEMP_R2}, 24'h251C9F);
    $display("Test table done");
    wb(1'h1, 8'h73, 8'h01);
    wb(1'h0, 8'h73, 8'h00);
    check("fan presence", q, 8'h0B);
    wb(1'h1, 8'h73, 8'h7F);
    wb(1'h0, 8'h73, 8'h00);
    check("fan bits read-only", q, 8'h7B);
    check("mode outputs", {AVERAGING_OFF, SINGLE_CHANNEL_CONVERT, ATTENUATOR_BYPASS}, 6'h3F);
    wait_done();
    wait_done();
    check("fast slot", per, 16);
    check("single channel", ACTIVE_CHANNEL, 3'h5);
    wb(1'h0, 8'h79, 8'h00);
    check("status channel", q[2:0], 3'h5);
    wb(1'h1, 8'h73, 8'h00);
    wb(1'h0, 8'h73, 8'h00);
    check("presence off", q, 8'h00);
    wait_done();
    ch = ACTIVE_CHANNEL;
    wait_done();
    check("slow slot", per, 256);
    check("round robin", ACTIVE_CHANNEL, 3'(ch + 3'h1));
    wb(1'h1, 8'h6F, 8'h00);
    check("test mode off", LOGIC_TREE_TEST_MODE, 1'h0);
    @(posedge CORE_CLK);
    SEL_I <= 4'hE;
    wb(1'h1, 8'h70, 8'hAA);
    @(posedge CORE_CLK);
    SEL_I <= 4'hF;
    wb(1'h0, 8'h70, 8'h00);
    check("write without lane", q, 8'h05);
    $display("Test modes done");
    wb(1'h1, 8'h78, 8'h02);
    for (int i = 0; i < 5; i++) begin
      wb(1'h1, 8'h6F + 8'(i), 8'h01);
      wb(1'h0, 8'h6F + 8'(i), 8'h00);
      check("locked register", q, locked[i]);
    end
    wb(1'h0, 8'h00, 8'h00);
    check("unmapped error", e, 1'h1);
    $display("Test lock done");
    @(posedge CORE_CLK);
    RST <= 1'h1;
    repeat (2) @(posedge CORE_CLK);
    RST <= 1'h0;
    wb(1'h1, 8'h70, 8'h33);
    wb(1'h0, 8'h70, 8'h00);
    check("lock cleared by reset", q, 8'h33);
    $display("Test second reset done");
    complete_run();
  end
endmodule // mcr_bank_tb_top
`default_nettype wire
